// ### design/fasc_params.svh
// Offsets, field positions, reset values and timing counts of the smoothing block
`ifndef FASC_PARAMS_SVH
`define FASC_PARAMS_SVH

// Register indices; byte address is four times the index
`define FASC_IDX_ACOU        8'h62
`define FASC_IDX_CFG         8'h70
`define FASC_IDX_ASSOC       8'h71
`define FASC_IDX_MIN_A       8'h72
`define FASC_IDX_MIN_B       8'h73
`define FASC_IDX_MIN_C       8'h74
`define FASC_IDX_DUTY_A      8'h75
`define FASC_IDX_DUTY_B      8'h76
`define FASC_IDX_DUTY_C      8'h77

// Fields of the acoustic smoothing control register
`define FASC_RATE_LSB        0
`define FASC_RATE_MSB        2
`define FASC_SMOOTH_BIT      3
`define FASC_SYNC_BIT        4
`define FASC_FLOOR_A_BIT     5
`define FASC_FLOOR_B_BIT     6
`define FASC_FLOOR_C_BIT     7

// Fields of the configuration register
`define FASC_LOCK_BIT        0
`define FASC_SLOTSEL_BIT     1
`define FASC_AUTO_BIT        2

// Reset values
`define FASC_ACOU_RST        8'h00
`define FASC_CFG_RST         8'h00
`define FASC_ASSOC_RST       8'h00
`define FASC_MIN_RST         8'h00

// Duty codes per slot for rate codes 0..7
`define FASC_STEP_0          8'd1
`define FASC_STEP_1          8'd2
`define FASC_STEP_2          8'd3
`define FASC_STEP_3          8'd4
`define FASC_STEP_4          8'd8
`define FASC_STEP_5          8'd12
`define FASC_STEP_6          8'd24
`define FASC_STEP_7          8'd48

// Timing: full ramp at one step per slot, in milliseconds
`define FASC_CLK_KHZ         64'd125000
`define FASC_FULL_STEPS      64'd255
`define FASC_RAMP0_MS        64'd37500
`define FASC_RAMP1_MS        64'd52200
`define FASC_SLOT0_CYC       ((`FASC_RAMP0_MS * `FASC_CLK_KHZ) / `FASC_FULL_STEPS)
`define FASC_SLOT1_CYC       ((`FASC_RAMP1_MS * `FASC_CLK_KHZ) / `FASC_FULL_STEPS)
`define FASC_PWM_DIV         32'd100
`define FASC_PWM_TOP         8'd254

`endif

// ### design/fasc_pkg.sv
// Types shared by the fan acoustic smoothing block
package fasc_pkg;
  typedef logic [7:0] fasc_duty_t;
  typedef logic [2:0] fasc_rate_t;
  typedef logic [7:0] fasc_idx_t;
  typedef logic [31:0] fasc_word_t;
endpackage

// ### design/fasc_ramp.sv
// Per-output duty slew limiter stepping once per time slot
`timescale 1ns/100ps
module fasc_ramp
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 slot_tick_i,
  input  wire logic                 smooth_en_i,
  input  wire fasc_pkg::fasc_duty_t target_i,
  input  wire fasc_pkg::fasc_duty_t step_i,
  output fasc_pkg::fasc_duty_t      duty_o
);
  import fasc_pkg::*;

  fasc_duty_t duty_r;
  logic [8:0] up_sum;
  logic [8:0] lim_hi;

  // Candidate values; nine bits so a large step cannot wrap past full scale
  assign up_sum = {1'b0, duty_r} + {1'b0, step_i};
  assign lim_hi = {1'b0, target_i} + {1'b0, step_i};

  ////////////////////////////////////////////////////////////////////////////
  // Duty state: jump when smoothing is off, else one step per slot
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      duty_r <= 8'h00;
    end
    else if (!smooth_en_i)
    begin
      duty_r <= target_i;
    end
    else if (slot_tick_i)
    begin
      // Rate is limited both ways, so a falling target also glides
      if (duty_r < target_i)
      begin
        duty_r <= (up_sum >= {1'b0, target_i}) ? target_i : up_sum[7:0];
      end
      else if (duty_r > target_i)
      begin
        duty_r <= ({1'b0, duty_r} <= lim_hi) ? target_i : duty_r - step_i;
      end
    end
  end

  assign duty_o = duty_r;

endmodule

// ### design/fasc_top.sv
// Fan acoustic smoothing control: register, slew limit, floor, tach sync, PWM
`timescale 1ns/100ps
`include "fasc_params.svh"
module fasc_top
#(
  parameter logic [31:0] SLOT0_CYC = 32'(`FASC_SLOT0_CYC),
  parameter logic [31:0] SLOT1_CYC = 32'(`FASC_SLOT1_CYC),
  parameter logic [31:0] PWM_DIV   = `FASC_PWM_DIV
)
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rstn_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [9:2]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire fasc_pkg::fasc_word_t wb_dat_i,
  output fasc_pkg::fasc_word_t      wb_dat_o,
  output logic                      wb_ack_o,
  input  wire fasc_pkg::fasc_duty_t loop_duty_a_i,
  input  wire fasc_pkg::fasc_duty_t loop_duty_b_i,
  input  wire fasc_pkg::fasc_duty_t loop_duty_c_i,
  input  wire logic [2:0]           below_hyst_i,
  output logic                      fan_drive_a_o,
  output logic                      fan_drive_b_o,
  output logic                      fan_drive_c_o,
  output logic                      sync_speed_in_2_o,
  output logic                      sync_speed_in_3_o,
  output logic                      sync_speed_in_4_o
);
  import fasc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser: asynchronous assert, two-flop release
  logic rst_ff1_r;
  logic rst_n_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_ff1_r <= 1'b0;
      rst_n_q   <= 1'b0;
    end
    else
    begin
      rst_ff1_r <= 1'b1;
      rst_n_q   <= rst_ff1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  fasc_duty_t       acou_r;
  fasc_duty_t       cfg_r;
  logic [2:0]       assoc_r;
  fasc_duty_t [2:0] min_r;
  fasc_duty_t [2:0] duty_w;
  fasc_duty_t [2:0] loop_duty;
  fasc_duty_t [2:0] target;
  logic [2:0]       smooth_on;
  logic [2:0]       floor_sel;
  logic             req;
  logic             wr_stb;
  logic             lane0;
  fasc_idx_t        idx;
  fasc_word_t       rd_mux;

  assign loop_duty = {loop_duty_c_i, loop_duty_b_i, loop_duty_a_i};
  assign floor_sel = {acou_r[`FASC_FLOOR_C_BIT], acou_r[`FASC_FLOOR_B_BIT],
                      acou_r[`FASC_FLOOR_A_BIT]};

  // Bus decode; a write lands only on the edge where the master sees ack
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign lane0  = wb_sel_i[0];
  assign idx    = wb_adr_i;

  ////////////////////////////////////////////////////////////////////////////
  // Acoustic smoothing control register, frozen once locked
  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      acou_r <= `FASC_ACOU_RST;
    end
    else if (wr_stb && lane0 && idx == `FASC_IDX_ACOU && !cfg_r[`FASC_LOCK_BIT])
    begin
      acou_r <= wb_dat_i[7:0];
    end
  end

  // Configuration: lock is sticky until reset, so software cannot undo it
  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cfg_r <= `FASC_CFG_RST;
    end
    else if (wr_stb && lane0 && idx == `FASC_IDX_CFG)
    begin
      cfg_r                  <= {5'h00, wb_dat_i[2:0]};
      cfg_r[`FASC_LOCK_BIT]  <= cfg_r[`FASC_LOCK_BIT] | wb_dat_i[`FASC_LOCK_BIT];
    end
  end

  // Channel ownership and minimum duties
  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      assoc_r <= 3'h0;
      min_r   <= {3{`FASC_MIN_RST}};
    end
    else if (wr_stb && lane0)
    begin
      case (idx)
        `FASC_IDX_ASSOC: assoc_r  <= wb_dat_i[2:0];
        `FASC_IDX_MIN_A: min_r[0] <= wb_dat_i[7:0];
        `FASC_IDX_MIN_B: min_r[1] <= wb_dat_i[7:0];
        `FASC_IDX_MIN_C: min_r[2] <= wb_dat_i[7:0];
        default:         assoc_r  <= assoc_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read zero and still get an ack
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `FASC_IDX_ACOU:   rd_mux[7:0] = acou_r;
      `FASC_IDX_CFG:    rd_mux[7:0] = cfg_r;
      `FASC_IDX_ASSOC:  rd_mux[2:0] = assoc_r;
      `FASC_IDX_MIN_A:  rd_mux[7:0] = min_r[0];
      `FASC_IDX_MIN_B:  rd_mux[7:0] = min_r[1];
      `FASC_IDX_MIN_C:  rd_mux[7:0] = min_r[2];
      `FASC_IDX_DUTY_A: rd_mux[7:0] = duty_w[0];
      `FASC_IDX_DUTY_B: rd_mux[7:0] = duty_w[1];
      `FASC_IDX_DUTY_C: rd_mux[7:0] = duty_w[2];
      default:          rd_mux      = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, dropped in the following cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot timer; period picked by the slot select bit
  logic [31:0] slot_cnt_r;
  logic [31:0] slot_lim;
  logic        slot_tick;

  assign slot_lim  = cfg_r[`FASC_SLOTSEL_BIT] ? SLOT1_CYC : SLOT0_CYC;
  assign slot_tick = (slot_cnt_r >= slot_lim - 32'd1);

  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      slot_cnt_r <= 32'h0000_0000;
    end
    else if (slot_tick)
    begin
      slot_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      slot_cnt_r <= slot_cnt_r + 32'd1;
    end
  end

  // Rate code to duty increment per slot
  function automatic fasc_duty_t step_of(input fasc_rate_t code);
    case (code)
      3'd0:    step_of = `FASC_STEP_0;
      3'd1:    step_of = `FASC_STEP_1;
      3'd2:    step_of = `FASC_STEP_2;
      3'd3:    step_of = `FASC_STEP_3;
      3'd4:    step_of = `FASC_STEP_4;
      3'd5:    step_of = `FASC_STEP_5;
      3'd6:    step_of = `FASC_STEP_6;
      default: step_of = `FASC_STEP_7;
    endcase
  endfunction

  fasc_duty_t step_val;
  assign step_val = step_of(acou_r[`FASC_RATE_MSB:`FASC_RATE_LSB]);

  ////////////////////////////////////////////////////////////////////////////
  // Per-output target, slew limiter and floor selection
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_chan
      // In auto mode, below start minus hysteresis the floor bit picks off or minimum
      assign target[g] = (cfg_r[`FASC_AUTO_BIT] && below_hyst_i[g]) ?
                         (floor_sel[g] ? min_r[g] : 8'h00) : loop_duty[g];
      // Only outputs owned by remote channel one are smoothed
      assign smooth_on[g] = acou_r[`FASC_SMOOTH_BIT] && assoc_r[g];

      fasc_ramp u_ramp
      (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_q),
        .slot_tick_i (slot_tick),
        .smooth_en_i (smooth_on[g]),
        .target_i    (target[g]),
        .step_i      (step_val),
        .duty_o      (duty_w[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // PWM: prescaler enable and 255-step period; 0xFF is fully on
  logic [31:0] pwm_div_r;
  logic        pwm_en;
  fasc_duty_t  pwm_cnt_r;

  assign pwm_en = (pwm_div_r >= PWM_DIV - 32'd1);

  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pwm_div_r <= 32'h0000_0000;
      pwm_cnt_r <= 8'h00;
    end
    else
    begin
      pwm_div_r <= pwm_en ? 32'h0000_0000 : pwm_div_r + 32'd1;
      if (pwm_en)
      begin
        pwm_cnt_r <= (pwm_cnt_r >= `FASC_PWM_TOP) ? 8'h00 : pwm_cnt_r + 8'd1;
      end
    end
  end

  // Drive outputs registered; a zero duty keeps the fan fully off
  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      fan_drive_a_o <= 1'b0;
      fan_drive_b_o <= 1'b0;
      fan_drive_c_o <= 1'b0;
    end
    else
    begin
      fan_drive_a_o <= pwm_cnt_r < duty_w[0];
      fan_drive_b_o <= pwm_cnt_r < duty_w[1];
      fan_drive_c_o <= pwm_cnt_r < duty_w[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed-input sync selects for the drive C measurement logic
  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sync_speed_in_2_o <= 1'b0;
      sync_speed_in_3_o <= 1'b0;
      sync_speed_in_4_o <= 1'b0;
    end
    else
    begin
      sync_speed_in_2_o <= acou_r[`FASC_SYNC_BIT];
      sync_speed_in_3_o <= 1'b1;
      sync_speed_in_4_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_q);

  logic acou_wr_try;
  assign acou_wr_try = wr_stb && lane0 && idx == `FASC_IDX_ACOU;

  AST_LOCK_FREEZE: assert property (
    cfg_r[`FASC_LOCK_BIT] && acou_wr_try |=> $stable(acou_r))
    else $error("locked smoothing register changed");

  AST_LOCK_STICKY: assert property (
    cfg_r[`FASC_LOCK_BIT] |=> cfg_r[`FASC_LOCK_BIT])
    else $error("lock bit cleared without reset");

  AST_RESET_ZERO: assert property (
    $rose(rst_n_q) |-> acou_r == 8'h00)
    else $error("smoothing register not zero after reset");

  AST_SYNC_THREE: assert property (
    acou_r[`FASC_SYNC_BIT] |=> sync_speed_in_2_o && sync_speed_in_3_o && sync_speed_in_4_o)
    else $error("speed input 2 not tied to drive C");

  AST_SYNC_TWO: assert property (
    rst_n_q && !acou_r[`FASC_SYNC_BIT] |=> !sync_speed_in_2_o && sync_speed_in_3_o)
    else $error("speed input 2 tied while sync off");

  AST_FLOOR_A: assert property (
    !smooth_on[0] && cfg_r[`FASC_AUTO_BIT] && below_hyst_i[0] && !acou_r[`FASC_FLOOR_A_BIT]
    |=> duty_w[0] == 8'h00)
    else $error("drive A not off below hysteresis");

  AST_FLOOR_B: assert property (
    !smooth_on[1] && cfg_r[`FASC_AUTO_BIT] && below_hyst_i[1] && acou_r[`FASC_FLOOR_B_BIT]
    |=> duty_w[1] == $past(min_r[1]))
    else $error("drive B not at minimum below hysteresis");

  AST_FLOOR_C: assert property (
    !smooth_on[2] && cfg_r[`FASC_AUTO_BIT] && below_hyst_i[2] && acou_r[`FASC_FLOOR_C_BIT]
    |=> duty_w[2] == $past(min_r[2]))
    else $error("drive C not at minimum below hysteresis");

  AST_IMMEDIATE: assert property (
    rst_n_q && !smooth_on[0] |=> duty_w[0] == $past(target[0]))
    else $error("unsmoothed duty did not jump");

  AST_HOLD_NO_SLOT: assert property (
    smooth_on[0] && !slot_tick |=> $stable(duty_w[0]))
    else $error("smoothed duty moved between slots");

  AST_STEP_BOUND: assert property (
    smooth_on[0] && slot_tick && duty_w[0] < target[0]
    |=> duty_w[0] > $past(duty_w[0]) && duty_w[0] - $past(duty_w[0]) <= $past(step_val))
    else $error("smoothed duty step out of range");

  AST_SLOT_WRAP: assert property (
    slot_tick |=> slot_cnt_r == 32'h0000_0000 ##1 slot_cnt_r == 32'h0000_0001)
    else $error("slot timer did not restart");

  COV_LOCKED_WRITE: cover property (cfg_r[`FASC_LOCK_BIT] && acou_wr_try);
  COV_RAMP_STEP:    cover property (smooth_on[0] && slot_tick && duty_w[0] != target[0]);
  COV_SYNC_ON:      cover property ($rose(sync_speed_in_2_o));
  COV_FLOOR_MIN:    cover property (below_hyst_i[2] && acou_r[`FASC_FLOOR_C_BIT]);

endmodule

// ### testbench/fasc_fan_model.sv
// Fan model: rotor speed follows the average drive over one PWM frame
`timescale 1ns/100ps
module fasc_fan_model
#(
  parameter int FRAME = 255
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       drive_i,
  output logic [7:0]      speed_o
);
  logic [FRAME-1:0] hist_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Rotor inertia: one frame of history, so a single glitch barely moves speed
  always_ff @(posedge clk_sys_i)
  begin
    hist_r <= {hist_r[FRAME-2:0], drive_i};
  end

  // Speed in duty counts; only valid once a full frame has been seen
  assign speed_o = 8'($countones(hist_r));
endmodule

// ### testbench/fan_acoustic_smoothing_config_bench.sv
// Self-checking bench for the fan acoustic smoothing block
`timescale 1ns/100ps
module fan_acoustic_smoothing_config_bench;
  import fasc_pkg::*;
  logic       clk_sys_i, rstn_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [9:2] wb_adr;
  logic [3:0] wb_sel;
  fasc_word_t wb_wdat, wb_rdat;
  fasc_duty_t loop_a, loop_b, loop_c;
  logic [2:0] below, drive, sync_out;
  logic [7:0] speed [3];
  logic [7:0] acou_m, min_m [3];
  logic       auto_m;
  logic [31:0] lfsr;
  int         n_fail, total_checks;
  int         cyc_cnt = 0;
  int         steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

  ////////////////////////////////////////////////////////////////////////////////
  // Short slots and a one-cycle PWM divider keep ramps and frames brief
  fasc_top #(.SLOT0_CYC(32'd20), .SLOT1_CYC(32'd28), .PWM_DIV(32'd1)) i_fasc_top
  (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .loop_duty_a_i(loop_a),
    .loop_duty_b_i(loop_b), .loop_duty_c_i(loop_c), .below_hyst_i(below),
    .fan_drive_a_o(drive[0]), .fan_drive_b_o(drive[1]), .fan_drive_c_o(drive[2]),
    .sync_speed_in_2_o(sync_out[0]), .sync_speed_in_3_o(sync_out[1]),
    .sync_speed_in_4_o(sync_out[2])
  );
  fasc_fan_model i_fan_a (.clk_sys_i(clk_sys_i), .drive_i(drive[0]), .speed_o(speed[0]));
  fasc_fan_model i_fan_b (.clk_sys_i(clk_sys_i), .drive_i(drive[1]), .speed_o(speed[1]));
  fasc_fan_model i_fan_c (.clk_sys_i(clk_sys_i), .drive_i(drive[2]), .speed_o(speed[2]));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and cycle counter
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) cyc_cnt <= cyc_cnt + 1;

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
  endfunction

  task automatic rnd8(output logic [7:0] v);
    lfsr = lfsr_next(lfsr);
    v = lfsr[7:0];
  endtask

  // Reference duty: floor handling in auto mode, else the loop value
  function automatic logic [7:0] model_duty(input int ch, input logic [7:0] lp);
    if (auto_m && below[ch])
      model_duty = acou_m[5+ch] ? min_m[ch] : 8'h00;
    else
      model_duty = lp;
  endfunction

  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_time(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Classic single Wishbone cycle; the wait is bounded so a dead slave ends the run
  task automatic wb_xfer(input logic [7:0] idx, input logic we, input logic [7:0] wd,
                         output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= idx;
    wb_wdat <= {24'h00_0000, wd};
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20)
    begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    wb_xfer(idx, 1'b1, wd, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    wb_xfer(idx, 1'b0, 8'h00, d);
    cmp_val(d, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] r, v, d;
    logic [7:0] lp [3];
    int s, tk, t0, sl, n;
    logic [7:0] tgt;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
    wb_sel = 4'hF;
    {loop_a, loop_b, loop_c, below} = '0;
    {n_fail, total_checks} = '0;
    lfsr = 32'h6d09_619e;
    acou_m = 8'h00;
    auto_m = 1'b0;
    rstn_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    cmp_val({5'b0, sync_out}, 8'h06);
    rd_chk(8'h62, 8'h00);
    rd_chk(8'h10, 8'h00);
    // Floor select, sync select and unsmoothed paths; owned outputs unsmoothed
    wr(8'h70, 8'h04);
    auto_m = 1'b1;
    repeat (10)
    begin
      rnd8(r);
      rnd8(v);
      acou_m = r;
      wr(8'h71, r[3] ? 8'h00 : {5'b0, v[2:0]});
      wr(8'h62, acou_m);
      for (int ch = 0; ch < 3; ch++)
      begin
        rnd8(min_m[ch]);
        wr(8'(8'h72 + ch), min_m[ch]);
        rnd8(lp[ch]);
      end
      rnd8(v);
      below  <= v[2:0];
      loop_a <= lp[0];
      loop_b <= lp[1];
      loop_c <= lp[2];
      repeat (260) @(posedge clk_sys_i);
      for (int ch = 0; ch < 3; ch++)
      begin
        rd_chk(8'(8'h75 + ch), model_duty(ch, lp[ch]));
        cmp_val(speed[ch], model_duty(ch, lp[ch]));
      end
      cmp_val({7'b0, sync_out[0]}, {7'b0, acou_m[4]});
      cmp_val({6'b0, sync_out[2:1]}, 8'h03);
    end
    // Ramp timing for every code, both slot periods, both directions
    auto_m = 1'b0;
    below <= 3'b000;
    wr(8'h71, 8'h01);
    for (int sel = 0; sel < 2; sel++)
      for (int c = 0; c < 8; c++)
        for (int up = 1; up >= 0; up--)
        begin
          s   = steps[c];
          sl  = sel ? 28 : 20;
          tk  = (255 + s - 1) / s;
          tgt = up ? 8'hFF : 8'h00;
          wr(8'h70, {6'b0, 1'(sel), 1'b0});
          wr(8'h62, {5'b0, 3'(c)});
          loop_a <= ~tgt;
          wr(8'h62, {5'b0_0001, 3'(c)});
          loop_a <= tgt;
          loop_b <= tgt;
          t0 = cyc_cnt;
          rd_chk(8'h76, tgt);
          n = 0;
          do
          begin
            wb_xfer(8'h75, 1'b0, 8'h00, v);
            d = up ? v : 8'hFF - v;
            cmp_val({7'b0, (v == tgt) || (d % s == 0)}, 8'h01);
            n++;
          end
          while (v !== tgt && n < 4000);
          if (n >= 4000)
          begin
            n_fail++;
            finish_test();
          end
          cmp_time(cyc_cnt - t0, (tk - 1) * sl, tk * sl + 8);
        end
    // Lock makes the control register read-only, and stays set
    wr(8'h62, 8'h5A);
    rd_chk(8'h62, 8'h5A);
    wr(8'h70, 8'h01);
    wr(8'h62, 8'hA5);
    rd_chk(8'h62, 8'h5A);
    wr(8'h70, 8'h00);
    rd_chk(8'h70, 8'h01);
    wr(8'h62, 8'h33);
    rd_chk(8'h62, 8'h5A);
    finish_test();
  end
endmodule
